// ==== dv/four_timer_bank_period_match_tb.sv ====
// Self-checking bench for the timer bank.
// Assumes the pin model drives the count pins.
module four_timer_bank_period_match_tb;
  import ftb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  ftb_req_t req = '0;
  logic [7:0] rdata;
  ftb_pins_t pins;
  logic [3:0] irq_req;
  logic edg;
  ftb_base_t base;
  logic [2:0] run = 3'h0;
  logic cap = 0;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] v;
  logic [7:0] r;
  logic [7:0] c;
  logic [7:0] pa;
  always #5 clk = ~clk;
  ftb_timer_bank dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .pins(pins),
    .irq_req(irq_req), .ext_irq_edge_select(edg), .base(base));
  ftb_pin_model u_pins (.clk(clk), .rst(rst), .run(run), .cap(cap), .pins(pins));
  task automatic finish_test();
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  function automatic logic near(input logic [15:0] got, input int exp);
    return (int'(got) + exp / 16 + 2 >= exp) && (int'(got) <= exp + exp / 16 + 6);
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Run one period timer setup and look just before and after the wrap
  task automatic span(input logic [7:0] ctl, input int b, input logic [7:0] p0,
                      input logic [7:0] p1, input int len, input int m);
    wr(A_TMR_CTRL, 8'h00);
    wr(A_PER_A, p0);
    wr(A_PER_B, p1);
    wr(A_WIDE_PL, p0);
    wr(A_WIDE_PH, p1);
    wr(A_CNT_A, 8'h00);
    wr(A_CNT_B, 8'h00);
    wr(A_WIDE_LOW, 8'h00);
    wr(A_WIDE_HIGH, 8'h00);
    wr(A_FLAGS, 8'h0F);
    wr(A_TMR_CTRL, ctl);
    repeat (len - m) @(posedge clk);
    @(negedge clk);
    check("flag early", irq_req[2:0], 3'h0);
    repeat (2 * m) @(posedge clk);
    @(negedge clk);
    check("flag wrap", irq_req[2:0], 3'h1 << b);
  endtask
  task automatic ovf_rate(input logic [7:0] ctl, input int exp);
    logic [7:0] lo;
    logic [7:0] hi;
    wr(A_OVF_CTRL, ctl);
    wr(A_OVF_HIGH, 8'h00);
    wr(A_OVF_LOW, 8'h00);
    repeat (256) @(posedge clk);
    rd(A_OVF_LOW, lo);
    rd(A_OVF_HIGH, hi);
    check("ovf rate", near({hi, lo}, exp), 1'b1);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 90000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    void'($urandom(32'h37863DE6));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(A_OVF_CTRL, r);
    check("ctrl reset", r, 8'h00);
    rd(5'h1F, r);
    check("unmapped", r, 8'h00);
    repeat (4)
    begin
      v = 8'($urandom);
      wr(A_OVF_CTRL, v);
      rd(A_OVF_CTRL, r);
      check("ctrl rw", r, v & 8'hFE);
      check("edge sel", edg, v[7]);
    end
    wr(A_OVF_CTRL, 8'h00);
    wr(A_IRQ_EN, 8'h0F);
    pa = 8'(20 + $urandom % 100);
    span(8'h01, F_A, pa, 8'h05, pa + 1, 4);
    span(8'h02, F_B, 8'h05, pa, pa + 1, 4);
    span(8'h43, F_A, pa, 8'h01, 257 + pa, 4);
    span(8'h04, F_WIDE, pa, 8'h01, 257 + pa, 4);
    run <= 3'h3;
    span(8'h09, F_A, 8'h05, 8'h00, 48, 12);
    span(8'h12, F_B, 8'h00, 8'h05, 48, 12);
    span(8'h24, F_WIDE, 8'h05, 8'h00, 48, 12);
    wr(A_TMR_CTRL, 8'h00);
    wr(A_IRQ_EN, 8'h00);
    @(negedge clk);
    check("masked", irq_req, 4'h0);
    wr(A_IRQ_EN, 8'h0F);
    @(negedge clk);
    check("unmasked", irq_req[F_WIDE], 1'b1);
    wr(A_FLAGS, 8'h04);
    @(negedge clk);
    check("cleared", irq_req[F_WIDE], 1'b0);
    run <= 3'h0;
    wr(A_TMR_CTRL, 8'h00);
    wr(A_WIDE_PL, 8'hFF);
    wr(A_WIDE_PH, 8'hFF);
    wr(A_WIDE_LOW, 8'h00);
    wr(A_TMR_CTRL, 8'h84);
    repeat (30) @(posedge clk);
    cap <= 1'b1;
    repeat (20) @(posedge clk);
    rd(A_WIDE_PL, c);
    rd(A_WIDE_LOW, r);
    cap <= 1'b0;
    check("capture", near(16'(r - c), 22), 1'b1);
    for (int n = 0; n < 10; n++)
      ovf_rate(8'h20 | 8'(n << 1), 256 >> (n > 8 ? 8 : n));
    run <= 3'h4;
    ovf_rate(8'h40, 32);
    ovf_rate(8'h00, 32);
    ovf_rate(8'h42, 16);
    run <= 3'h0;
    wr(A_OVF_CTRL, 8'h20);
    wr(A_FLAGS, 8'h0F);
    @(negedge clk);
    check("ovf no flag", irq_req[F_OVF], 1'b0);
    wr(A_OVF_HIGH, 8'hFF);
    wr(A_OVF_LOW, 8'hF0);
    repeat (30) @(posedge clk);
    @(negedge clk);
    check("ovf flag", irq_req[F_OVF], 1'b1);
    finish_test();
  end
endmodule

// ==== dv/ftb_pin_model.sv ====
// External count clocks and capture input of the timer bank.
// Assumes the bench picks which pins run; idle pins rest low.
module ftb_pin_model
  import ftb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  run,
  input  wire logic        cap,
  output ftb_pkg::ftb_pins_t pins
);
  logic [2:0] div;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end
  // One rising and one falling edge every 8 cycles
  assign pins.shared_count_pin   = run[0] & div[2];
  assign pins.wide_count_pin     = run[1] & div[2];
  assign pins.overflow_clock_pin = run[2] & div[2];
  assign pins.capture2_pin       = cap;
endmodule

// ==== dv/ftb_timer_bank_props.sv ====
// Checker for the timer bank's register port, flags and edge select.
// Assumes one clock and an asynchronous active-high reset.
module ftb_timer_bank_props
  import ftb_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire ftb_pkg::ftb_req_t           req,
  input  wire logic [ftb_pkg::DATA_W-1:0]  rdata,
  input  wire ftb_pkg::ftb_pins_t          pins,
  input  wire logic [ftb_pkg::N_FLAGS-1:0] irq_req,
  input  wire logic                        ext_irq_edge_select,
  input  wire ftb_pkg::ftb_base_t          base
);
  logic [7:0] shadow;
  logic       wr_ctl;
  logic       en_wr;
  logic       clr_wr;
  logic       rd_ctl;
  logic       a_why;
  logic       w_why;
  assign wr_ctl = req.wr && (req.addr == A_OVF_CTRL);
  assign rd_ctl = req.rd && (req.addr == A_OVF_CTRL);
  assign en_wr  = req.wr && (req.addr == A_IRQ_EN);
  assign clr_wr = en_wr || (req.wr && (req.addr == A_FLAGS));
  assign a_why  = base.pwm_base_a_wrap | base.pwm_base_b_wrap | en_wr;
  assign w_why  = base.capture_base_wrap | en_wr;
  // Expected control contents
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      shadow <= 8'h00;
    else if (wr_ctl)
      shadow <= req.wdata & OVF_CTRL_MASK;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_idle_a: assert property (!req.rd |=> rdata == 8'h00)
    else $error("read data not idle");
  ctrl_read_a: assert property (rd_ctl |=> rdata == shadow)
    else $error("control read wrong");
  bit0_zero_a: assert property (rd_ctl |=> !rdata[0])
    else $error("control bit0 not zero");
  edge_follow_a: assert property (wr_ctl |=> ext_irq_edge_select == $past(req.wdata[7]))
    else $error("edge select not written");
  edge_hold_a: assert property (!$stable(ext_irq_edge_select) |-> $past(wr_ctl))
    else $error("edge select moved alone");
  unmapped_a: assert property ((req.rd && (req.addr > A_CAP2_HIGH)) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_a_cause_a: assert property ($rose(irq_req[F_A]) |-> $past(a_why))
    else $error("timer A request without wrap");
  irq_w_cause_a: assert property ($rose(irq_req[F_WIDE]) |-> $past(w_why))
    else $error("wide request without wrap");
  irq_clear_a: assert property ((|($past(irq_req) & ~irq_req)) |-> $past(clr_wr))
    else $error("request dropped alone");
endmodule

bind ftb_timer_bank ftb_timer_bank_props u_props (.clk(clk), .rst(rst), .req(req),
  .rdata(rdata), .pins(pins), .irq_req(irq_req),
  .ext_irq_edge_select(ext_irq_edge_select), .base(base));

// ==== src/ftb_pkg.sv ====
// Package for the four-timer bank: register indices, field positions, resets.
// Assumes an 8-bit register port on the instruction clock.
package ftb_pkg;
  localparam int          ADDR_W   = 5;
  localparam int          DATA_W   = 8;
  // Register indices (byte addresses on the register port)
  localparam logic [4:0]  A_OVF_CTRL   = 5'h05;
  localparam logic [4:0]  A_OVF_LOW    = 5'h06;
  localparam logic [4:0]  A_OVF_HIGH   = 5'h07;
  localparam logic [4:0]  A_CNT_A      = 5'h08;
  localparam logic [4:0]  A_CNT_B      = 5'h09;
  localparam logic [4:0]  A_PER_A      = 5'h0A;
  localparam logic [4:0]  A_PER_B      = 5'h0B;
  localparam logic [4:0]  A_WIDE_LOW   = 5'h0C;
  localparam logic [4:0]  A_WIDE_HIGH  = 5'h0D;
  localparam logic [4:0]  A_WIDE_PL    = 5'h0E;
  localparam logic [4:0]  A_WIDE_PH    = 5'h0F;
  localparam logic [4:0]  A_TMR_CTRL   = 5'h10;
  localparam logic [4:0]  A_FLAGS      = 5'h11;
  localparam logic [4:0]  A_IRQ_EN     = 5'h12;
  localparam logic [4:0]  A_CAP2_LOW   = 5'h13;
  localparam logic [4:0]  A_CAP2_HIGH  = 5'h14;
  // Overflow timer control fields
  localparam int          B_EDGE_IRQ   = 7;
  localparam int          B_EDGE_CNT   = 6;
  localparam int          B_CLK_SRC    = 5;
  localparam int          B_PS_HI      = 4;
  localparam int          B_PS_LO      = 1;
  localparam logic [7:0]  OVF_CTRL_MASK = 8'hFE;
  // Timer control fields
  localparam int          B_A_ON       = 0;
  localparam int          B_B_ON       = 1;
  localparam int          B_WIDE_ON    = 2;
  localparam int          B_A_EXT      = 3;
  localparam int          B_B_EXT      = 4;
  localparam int          B_WIDE_EXT   = 5;
  localparam int          B_JOIN       = 6;
  localparam int          B_QUAD_CAP   = 7;
  // Flag / enable bit positions
  localparam int          F_A          = 0;
  localparam int          F_B          = 1;
  localparam int          F_WIDE       = 2;
  localparam int          F_OVF        = 3;
  localparam int          N_FLAGS      = 4;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [15:0] ONE_WORD     = 16'h0001;
  localparam logic [7:0]  ONE_BYTE     = 8'h01;
  localparam logic [3:0]  PS_MAX       = 4'h8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ftb_req_t;

  typedef struct packed {
    logic shared_count_pin;
    logic wide_count_pin;
    logic overflow_clock_pin;
    logic capture2_pin;
  } ftb_pins_t;

  typedef struct packed {
    logic pwm_base_a_wrap;
    logic pwm_base_b_wrap;
    logic capture_base_wrap;
  } ftb_base_t;
endpackage

// ==== src/ftb_timer_bank.sv ====
// Four-timer bank: overflow timer with prescaler, two joinable period timers,
// wide period timer. Assumes pins are asynchronous and software uses the port.
// How it works
// - Timer A has own period register; wrap from match to zero sets its flag.
// - Timer A external mode counts shared pin; timer B may use it too.
// - Join mode chains A low byte, B high byte, periods form 16 bits.
// - Joined count wrapping from 16-bit match sets timer A's flag.
// - Timer B alone wraps at its own period and sets its flag.
// - Flags raise interrupt request only when matching enable is set.
// - Wide timer has split count bytes, 16-bit period, wrap sets flag.
// - Wide timer external mode counts its own dedicated pin.
// - Four-capture mode turns wide period registers into capture register two.
// - Timers A and B feed PWM bases; wide timer feeds capture base.
// - Overflow counter is 16 bits, reached as low and high bytes.
// - Eight-bit prescaler ahead of the overflow counter gives 24 bits.
// - Overflow clock source selects instruction clock or external pin.
// - Control register at 05h: irq edge, source, prescale; resets zero.
// - Control bit 0 is unimplemented and reads zero.
// - Prescale select gives ratios 1:1 up to 1:256.
// - External overflow clock may count rising or falling edge.
// - External overflow clock synchronised after prescaler, not before.
//
// Our own choice: strobed register access.
module ftb_timer_bank
  import ftb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ftb_pkg::ftb_req_t      req,
  output logic [ftb_pkg::DATA_W-1:0]  rdata,
  input  wire ftb_pkg::ftb_pins_t     pins,
  output logic [ftb_pkg::N_FLAGS-1:0] irq_req,
  output logic                        ext_irq_edge_select,
  output ftb_pkg::ftb_base_t          base
);
  import ftb_pkg::*;

  logic [7:0]         overflow_timer_control;
  logic [7:0]         tmr_ctrl;
  logic [N_FLAGS-1:0] flags;
  logic [N_FLAGS-1:0] irq_en;
  logic [7:0]         count_a_reg;
  logic [7:0]         count_b_reg;
  logic [7:0]         period_a_reg;
  logic [7:0]         period_b_reg;
  logic [15:0]        wide_count;
  logic [15:0]        wide_period;
  logic [15:0]        capture2;
  logic [15:0]        overflow_counter;
  logic [7:0]         prescale;
  logic               ext_div;
  logic [2:0]         sh_sync;
  logic [2:0]         wd_sync;
  logic [2:0]         cp_sync;
  logic [2:0]         ov_sync;

  wire wr_en = req.wr;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sh_sync <= 3'h0;
      wd_sync <= 3'h0;
      cp_sync <= 3'h0;
    end
    else
    begin
      sh_sync <= {sh_sync[1:0], pins.shared_count_pin};
      wd_sync <= {wd_sync[1:0], pins.wide_count_pin};
      cp_sync <= {cp_sync[1:0], pins.capture2_pin};
    end
  end

  wire sh_rise = sh_sync[1] & ~sh_sync[2];
  wire wd_rise = wd_sync[1] & ~wd_sync[2];
  wire cp_rise = cp_sync[1] & ~cp_sync[2];

  // Overflow timer prescale: the raw pin edge clocks a divider bit ahead of sync
  wire [3:0] ps_sel   = overflow_timer_control[B_PS_HI:B_PS_LO];
  wire       ext_mode = ~overflow_timer_control[B_CLK_SRC];
  wire       ext_lvl  = pins.overflow_clock_pin ^ ~overflow_timer_control[B_EDGE_CNT];

  // Ripple divider on the pin (pin-side logic); its output is then synchronised
  // Lets the pin run faster than clk at prescales of 1:8 and above: only the divided level must
  // meet the synchroniser's two-cycle high and low times.
  // Changing the edge select can itself make one stray divider step.
  logic [7:0] ext_chain;
  always_ff @(posedge ext_lvl or posedge rst)
  begin
    if (rst)
      ext_chain <= RST_BYTE;
    else
      ext_chain <= ext_chain + ONE_BYTE;
  end

  always_comb
  begin
    if (ps_sel == 4'h0)
      ext_div = ext_lvl;
    else if (ps_sel >= PS_MAX)
      ext_div = ext_chain[7];
    else
      ext_div = ext_chain[3'(ps_sel - 4'h1)];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ov_sync <= 3'h0;
    else
      ov_sync <= {ov_sync[1:0], ext_div};
  end

  wire ov_ext_tick = ov_sync[1] & ~ov_sync[2];

  // Internal prescale of the instruction clock
  wire [7:0] ps_top = (ps_sel >= PS_MAX) ? 8'hFF : 8'((9'h001 << ps_sel) - 9'h001);
  wire       int_tick = (prescale >= ps_top);
  wire       ov_tick  = ext_mode ? ov_ext_tick : int_tick;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prescale <= RST_BYTE;
    else if (ext_mode || int_tick)
      prescale <= RST_BYTE;
    else
      prescale <= prescale + ONE_BYTE;
  end

  wire ov_wrap = ov_tick & (overflow_counter == 16'hFFFF);

  // A byte write wins over a tick in the same cycle

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      overflow_counter <= RST_WORD;
    else if (wr_en && req.addr == A_OVF_LOW)
      overflow_counter[7:0] <= req.wdata;
    else if (wr_en && req.addr == A_OVF_HIGH)
      overflow_counter[15:8] <= req.wdata;
    else if (ov_tick)
      overflow_counter <= overflow_counter + ONE_WORD;
  end

  // Period timers A and B
  // Joined: B steps on A's carry; only the full 16-bit match wraps both
  wire join_m  = tmr_ctrl[B_JOIN];
  wire a_tick  = tmr_ctrl[B_A_ON] & (tmr_ctrl[B_A_EXT] ? sh_rise : 1'b1);
  wire b_tick  = tmr_ctrl[B_B_ON] & (tmr_ctrl[B_B_EXT] ? sh_rise : 1'b1);
  wire a_match = (count_a_reg == period_a_reg);
  wire b_match = (count_b_reg == period_b_reg);
  wire j_match = a_match & b_match;
  wire a_wrap  = join_m ? (a_tick & j_match) : (a_tick & a_match);
  wire b_wrap  = ~join_m & b_tick & b_match;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_a_reg <= RST_BYTE;
    else if (wr_en && req.addr == A_CNT_A)
      count_a_reg <= req.wdata;
    else if (a_wrap)
      count_a_reg <= RST_BYTE;
    else if (a_tick)
      count_a_reg <= count_a_reg + ONE_BYTE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_b_reg <= RST_BYTE;
    else if (wr_en && req.addr == A_CNT_B)
      count_b_reg <= req.wdata;
    else if (join_m)
    begin
      if (a_wrap)
        count_b_reg <= RST_BYTE;
      else if (a_tick && count_a_reg == 8'hFF)
        count_b_reg <= count_b_reg + ONE_BYTE;
    end
    else if (b_wrap)
      count_b_reg <= RST_BYTE;
    else if (b_tick)
      count_b_reg <= count_b_reg + ONE_BYTE;
  end

  // Wide timer and its period / capture register
  // In four-capture mode period writes still land but read back the capture
  wire quad_cap = tmr_ctrl[B_QUAD_CAP];
  wire w_tick   = tmr_ctrl[B_WIDE_ON] & (tmr_ctrl[B_WIDE_EXT] ? wd_rise : 1'b1);
  wire w_wrap   = w_tick & (wide_count == wide_period);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wide_count <= RST_WORD;
    else if (wr_en && req.addr == A_WIDE_LOW)
      wide_count[7:0] <= req.wdata;
    else if (wr_en && req.addr == A_WIDE_HIGH)
      wide_count[15:8] <= req.wdata;
    else if (w_wrap)
      wide_count <= RST_WORD;
    else if (w_tick)
      wide_count <= wide_count + ONE_WORD;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      capture2 <= RST_WORD;
    else if (quad_cap && cp_rise)
      capture2 <= wide_count;
  end

  // Software registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      overflow_timer_control <= RST_BYTE;
      tmr_ctrl     <= RST_BYTE;
      period_a_reg <= RST_BYTE;
      period_b_reg <= RST_BYTE;
      wide_period  <= RST_WORD;
      irq_en       <= '0;
    end
    else if (wr_en)
    begin
      case (req.addr)
        A_OVF_CTRL:  overflow_timer_control <= req.wdata & OVF_CTRL_MASK;
        A_TMR_CTRL:  tmr_ctrl <= req.wdata;
        A_PER_A:     period_a_reg <= req.wdata;
        A_PER_B:     period_b_reg <= req.wdata;
        A_WIDE_PL:   wide_period[7:0] <= req.wdata;
        A_WIDE_PH:   wide_period[15:8] <= req.wdata;
        A_IRQ_EN:    irq_en <= req.wdata[N_FLAGS-1:0];
        default:     ;
      endcase
    end
  end

  // Flags: write one to clear, a new event wins
  wire [N_FLAGS-1:0] ev;
  assign ev[F_A]    = a_wrap;
  assign ev[F_B]    = b_wrap;
  assign ev[F_WIDE] = w_wrap;
  assign ev[F_OVF]  = ov_wrap;
  wire [N_FLAGS-1:0] clr = (wr_en && req.addr == A_FLAGS) ? req.wdata[N_FLAGS-1:0] : '0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flags <= '0;
    else
      flags <= (flags & ~clr) | ev;
  end

  assign irq_req             = flags & irq_en;
  assign ext_irq_edge_select = overflow_timer_control[B_EDGE_IRQ];
  assign base.pwm_base_a_wrap   = a_wrap;
  assign base.pwm_base_b_wrap   = b_wrap;
  assign base.capture_base_wrap = w_wrap;

  // Read port: data in the cycle after the strobe
  // Idle cycles and unused addresses read zero so stale data never shows
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= RST_BYTE;
    else if (req.rd)
    begin
      case (req.addr)
        A_OVF_CTRL:  rdata <= overflow_timer_control;
        A_OVF_LOW:   rdata <= overflow_counter[7:0];
        A_OVF_HIGH:  rdata <= overflow_counter[15:8];
        A_CNT_A:     rdata <= count_a_reg;
        A_CNT_B:     rdata <= count_b_reg;
        A_PER_A:     rdata <= period_a_reg;
        A_PER_B:     rdata <= period_b_reg;
        A_WIDE_LOW:  rdata <= wide_count[7:0];
        A_WIDE_HIGH: rdata <= wide_count[15:8];
        A_WIDE_PL:   rdata <= quad_cap ? capture2[7:0] : wide_period[7:0];
        A_WIDE_PH:   rdata <= quad_cap ? capture2[15:8] : wide_period[15:8];
        A_TMR_CTRL:  rdata <= tmr_ctrl;
        A_FLAGS:     rdata <= {{(8-N_FLAGS){1'b0}}, flags};
        A_IRQ_EN:    rdata <= {{(8-N_FLAGS){1'b0}}, irq_en};
        A_CAP2_LOW:  rdata <= capture2[7:0];
        A_CAP2_HIGH: rdata <= capture2[15:8];
        default:     rdata <= RST_BYTE;
      endcase
    end
    else
      rdata <= RST_BYTE;
  end
endmodule
